// ===== logic/rtvu_top.sv
// Overview of operation
// - Reset beats all exceptions; pin low halts
// - Watchdog overflow resets like pin
// - Reset inits state, interrupt mode 0
// - Release clears base, trace; sets masks
// - Fetch reset vector into program counter
// - Block all interrupts until first instruction
// - Halt controls become 0FFF and FFFF
// - Halted peripheral register access ignored
// - Reset, CPU address error: offset only
// - Four-byte entries, IRQ and internal ranges
// - Never generate user or reserved vectors
// - DMA address error from transfer controllers
// - Trace only in mode 2
// - Trace after each instruction, ignores mask
// - Trace entry sets I, clears T
// - Stacked trace bit stays 1
// - No trace after return instruction
// - Only NMI among interrupts accepted inside trace handler while I is set
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
module rtvu_top (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic chip_init_pin_n_in,
   input wire logic wdt_overflow_in,
   // Core side
   input wire logic instr_done_in,
   input wire logic instr_is_rte_in,
   input wire logic illegal_instr_in,
   input wire logic cpu_addr_err_in,
   input wire logic xfer_addr_err_in,
   input wire logic nmi_in,
   input wire logic sleep_intr_in,
   input wire logic [11:0] irq_in,
   input wire logic internal_intr_in,
   input wire logic [7:0] internal_vec_in,
   input wire logic trap_in,
   input wire logic [1:0] trap_num_in,
   input wire logic [2:0] irq_prio_in,
   // Vector fetch port
   output logic fetch_req_out,
   output logic [31:0] fetch_addr_out,
   input wire logic fetch_ack_in,
   input wire logic [31:0] fetch_data_in,
   output logic exc_start_out,
   output logic [7:0] exc_vec_out,
   output logic [7:0] stacked_exr_out,
   output logic [7:0] stacked_ccr_out,
   output logic [31:0] pc_out,
   output logic pc_load_out,
   output logic cpu_in_reset_out,
   output logic [15:0] module_halt_a_out,
   output logic [15:0] module_halt_b_out,
   // AXI4-Lite
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef struct packed {
      rtvu_pkg::rtvu_state_t st;
      logic [31:0] vector_base_reg;
      logic [7:0] cond_code_reg;
      logic [7:0] extended_ctrl_reg;
      logic [1:0] mode;
      logic [15:0] halt_a;
      logic [15:0] halt_b;
      logic intr_block;
      logic [7:0] vec;
      logic [31:0] faddr;
      logic [31:0] pc;
      logic pc_load;
      logic exc_start;
      logic [7:0] st_exr;
      logic [7:0] st_ccr;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } rtvu_regs_t;

   rtvu_regs_t r;
   rtvu_regs_t next_r;
   logic wdt_reset;

   // Vector offset, entries are 4 bytes
   function automatic logic [31:0] vec_offset(input logic [7:0] v);
      vec_offset = {22'h00_0000, v, 2'h0};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      merge = res;
   endfunction

   function automatic logic [8:0] pick_vec(input logic trace_ok, input logic intr_ok);
      logic [8:0] res;
      res = 9'h000;
      if (illegal_instr_in) begin
         res = {1'b1, rtvu_pkg::VEC_ILLEGAL};
      end else if (trace_ok) begin
         res = {1'b1, rtvu_pkg::VEC_TRACE};
      end else if (cpu_addr_err_in) begin
         res = {1'b1, rtvu_pkg::VEC_CPU_ADDR_ERR};
      end else if (xfer_addr_err_in) begin
         res = {1'b1, rtvu_pkg::VEC_DMA_ADDR_ERR};
      end else if (intr_ok && nmi_in) begin
         res = {1'b1, rtvu_pkg::VEC_NMI};
      end else if (intr_ok && !r.cond_code_reg[rtvu_pkg::CCR_I_BIT] && sleep_intr_in) begin
         res = {1'b1, rtvu_pkg::VEC_SLEEP};
      end else if (intr_ok && !r.cond_code_reg[rtvu_pkg::CCR_I_BIT] && (|irq_in)) begin
         res = 9'h000;
         for (int i = rtvu_pkg::IRQ_LINES - 1; i >= 0; i--) begin
            if (irq_in[i]) begin
               res = {1'b1, rtvu_pkg::VEC_IRQ_BASE + 8'(i)};
            end
         end
      end else if (intr_ok && !r.cond_code_reg[rtvu_pkg::CCR_I_BIT] && internal_intr_in
                   && internal_vec_in >= rtvu_pkg::VEC_INTERNAL_MIN) begin
         res = {1'b1, internal_vec_in};
      end else if (trap_in) begin
         res = {1'b1, rtvu_pkg::VEC_TRAP0 + {6'h00, trap_num_in}};
      end
      pick_vec = res;
   endfunction

   always_comb begin
      logic trace_ok;
      logic intr_ok;
      logic [8:0] sel;
      logic [7:0] exr_new;
      logic [7:0] ccr_new;
      logic [31:0] wm;
      trace_ok = 1'b0;
      intr_ok = 1'b0;
      sel = 9'h000;
      exr_new = 8'h00;
      ccr_new = 8'h00;
      wm = 32'h0000_0000;
      next_r = r;
      next_r.pc_load = 1'b0;
      next_r.exc_start = 1'b0;
      case (r.st)
         rtvu_pkg::ST_RESET: begin
            next_r.vector_base_reg = rtvu_pkg::VBR_RESET;
            next_r.extended_ctrl_reg[rtvu_pkg::EXR_T_BIT] = 1'b0;
            next_r.extended_ctrl_reg[2:0] = 3'h7;
            next_r.cond_code_reg[rtvu_pkg::CCR_I_BIT] = 1'b1;
            next_r.halt_a = rtvu_pkg::HALT_A_RESET;
            next_r.halt_b = rtvu_pkg::HALT_B_RESET;
            next_r.vec = rtvu_pkg::VEC_RESET;
            next_r.faddr = vec_offset(rtvu_pkg::VEC_RESET);
            next_r.intr_block = 1'b1;
            next_r.st = rtvu_pkg::ST_FETCH;
         end
         rtvu_pkg::ST_FETCH: begin
            if (fetch_ack_in) begin
               next_r.pc = fetch_data_in;
               next_r.pc_load = 1'b1;
               next_r.st = rtvu_pkg::ST_RUN;
            end
         end
         rtvu_pkg::ST_RUN: begin
            if (instr_done_in) begin
               next_r.intr_block = 1'b0;
               trace_ok = r.extended_ctrl_reg[rtvu_pkg::EXR_T_BIT] && r.mode == rtvu_pkg::INTR_MODE_2
                          && !instr_is_rte_in;
               intr_ok = !r.intr_block;
               sel = pick_vec(trace_ok, intr_ok);
               if (sel[8]) begin
                  exr_new = r.extended_ctrl_reg;
                  ccr_new = r.cond_code_reg;
                  ccr_new[rtvu_pkg::CCR_I_BIT] = 1'b1;
                  if (r.mode == rtvu_pkg::INTR_MODE_2) begin
                     exr_new[rtvu_pkg::EXR_T_BIT] = 1'b0;
                     if (sel[7:0] == rtvu_pkg::VEC_CPU_ADDR_ERR) begin
                        exr_new[2:0] = 3'h7;
                     end else if (sel[7:0] != rtvu_pkg::VEC_TRACE
                                  && sel[7:0] >= rtvu_pkg::VEC_IRQ_BASE) begin
                        exr_new[2:0] = irq_prio_in;
                     end
                  end
                  next_r.st_exr = r.extended_ctrl_reg;
                  next_r.st_ccr = r.cond_code_reg;
                  next_r.extended_ctrl_reg = exr_new;
                  next_r.cond_code_reg = ccr_new;
                  next_r.vec = sel[7:0];
                  next_r.exc_start = 1'b1;
                  if (sel[7:0] == rtvu_pkg::VEC_CPU_ADDR_ERR) begin
                     next_r.faddr = vec_offset(sel[7:0]);
                  end else begin
                     next_r.faddr = r.vector_base_reg + vec_offset(sel[7:0]);
                  end
                  next_r.st = rtvu_pkg::ST_FETCH;
               end
            end
         end
         default: begin
            next_r.st = rtvu_pkg::ST_RESET;
         end
      endcase

      // Register slave; one write and one read at a time
      if (s_axi_awvalid && !r.aw_got && !r.bvalid) begin
         next_r.aw_got = 1'b1;
         next_r.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.w_got && !r.bvalid) begin
         next_r.w_got = 1'b1;
         next_r.wdata = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
      end
      if (r.aw_got && r.w_got) begin
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = rtvu_pkg::RESP_OKAY;
         case (r.awaddr)
            rtvu_pkg::ADDR_VBR: next_r.vector_base_reg = merge(r.vector_base_reg, r.wdata, r.wstrb);
            rtvu_pkg::ADDR_CCR: begin
               wm = merge({24'h00_0000, r.cond_code_reg}, r.wdata, r.wstrb);
               next_r.cond_code_reg = wm[7:0];
            end
            rtvu_pkg::ADDR_EXR: begin
               wm = merge({24'h00_0000, r.extended_ctrl_reg}, r.wdata, r.wstrb);
               next_r.extended_ctrl_reg = wm[7:0];
            end
            rtvu_pkg::ADDR_HALT_A: begin
               wm = merge({16'h0000, r.halt_a}, r.wdata, r.wstrb);
               next_r.halt_a = wm[15:0];
            end
            rtvu_pkg::ADDR_HALT_B: begin
               wm = merge({16'h0000, r.halt_b}, r.wdata, r.wstrb);
               next_r.halt_b = wm[15:0];
            end
            rtvu_pkg::ADDR_MODE: begin
               if (r.wstrb[0] && (r.wdata[1:0] == rtvu_pkg::INTR_MODE_0
                                   || r.wdata[1:0] == rtvu_pkg::INTR_MODE_2)) begin
                  next_r.mode = r.wdata[1:0];
               end
            end
            rtvu_pkg::ADDR_STATUS: begin
            end
            default: next_r.bresp = rtvu_pkg::RESP_SLVERR;
         endcase
      end
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !r.rvalid) begin
         next_r.rvalid = 1'b1;
         next_r.rresp = rtvu_pkg::RESP_OKAY;
         case (s_axi_araddr)
            rtvu_pkg::ADDR_VBR: next_r.rdata = r.vector_base_reg;
            rtvu_pkg::ADDR_CCR: next_r.rdata = {24'h00_0000, r.cond_code_reg};
            rtvu_pkg::ADDR_EXR: next_r.rdata = {24'h00_0000, r.extended_ctrl_reg};
            rtvu_pkg::ADDR_HALT_A: next_r.rdata = {16'h0000, r.halt_a};
            rtvu_pkg::ADDR_HALT_B: next_r.rdata = {16'h0000, r.halt_b};
            rtvu_pkg::ADDR_MODE: next_r.rdata = {30'h0000_0000, r.mode};
            rtvu_pkg::ADDR_STATUS: next_r.rdata = {20'h0_0000, r.vec, r.st};
            default: begin
               next_r.rdata = 32'h0000_0000;
               next_r.rresp = rtvu_pkg::RESP_SLVERR;
            end
         endcase
      end else if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
      end
   end

   // reset input or pin forces reset state
   assign wdt_reset = !resetn_in || !chip_init_pin_n_in;

   always_ff @(posedge core_clk_in or posedge wdt_reset) begin
      if (wdt_reset) begin
         r <= '{st: rtvu_pkg::ST_RESET, vector_base_reg: rtvu_pkg::VBR_RESET, cond_code_reg: 8'h80, extended_ctrl_reg: 8'h07,
                mode: rtvu_pkg::INTR_MODE_0, halt_a: rtvu_pkg::HALT_A_RESET,
                halt_b: rtvu_pkg::HALT_B_RESET, intr_block: 1'b1, default: '0};
      end else if (wdt_overflow_in) begin
         r <= '{st: rtvu_pkg::ST_RESET, vector_base_reg: rtvu_pkg::VBR_RESET, cond_code_reg: 8'h80, extended_ctrl_reg: 8'h07,
                mode: rtvu_pkg::INTR_MODE_0, halt_a: rtvu_pkg::HALT_A_RESET,
                halt_b: rtvu_pkg::HALT_B_RESET, intr_block: 1'b1, default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign fetch_req_out = r.st == rtvu_pkg::ST_FETCH;
   assign fetch_addr_out = r.faddr;
   assign exc_start_out = r.exc_start;
   assign exc_vec_out = r.vec;
   assign stacked_exr_out = r.st_exr;
   assign stacked_ccr_out = r.st_ccr;
   assign pc_out = r.pc;
   assign pc_load_out = r.pc_load;
   assign cpu_in_reset_out = r.st == rtvu_pkg::ST_RESET;
   // peripherals gate access on these bits
   assign module_halt_a_out = r.halt_a;
   assign module_halt_b_out = r.halt_b;
   assign s_axi_awready = !r.aw_got && !r.bvalid;
   assign s_axi_wready = !r.w_got && !r.bvalid;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = !r.rvalid;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
endmodule

// ===== logic/rtvu_pkg.sv
package rtvu_pkg;
   // Vector numbers
   localparam logic [7:0] VEC_RESET = 8'h00;
   localparam logic [7:0] VEC_ILLEGAL = 8'h04;
   localparam logic [7:0] VEC_TRACE = 8'h05;
   localparam logic [7:0] VEC_NMI = 8'h07;
   localparam logic [7:0] VEC_TRAP0 = 8'h08;
   localparam logic [7:0] VEC_CPU_ADDR_ERR = 8'h0c;
   localparam logic [7:0] VEC_DMA_ADDR_ERR = 8'h0d;
   localparam logic [7:0] VEC_SLEEP = 8'h12;
   localparam logic [7:0] VEC_IRQ_BASE = 8'h40;
   localparam logic [7:0] VEC_INTERNAL_MIN = 8'h50;
   localparam int IRQ_LINES = 12;
   // Entry size shift in advanced mode (4 bytes)
   localparam int VEC_SHIFT = 2;
   localparam logic [31:0] VBR_RESET = 32'h0000_0000;
   localparam logic [15:0] HALT_A_RESET = 16'h0fff;
   localparam logic [15:0] HALT_B_RESET = 16'hffff;
   localparam logic [1:0] INTR_MODE_0 = 2'h0;
   localparam logic [1:0] INTR_MODE_2 = 2'h2;
   // Bit positions
   localparam int CCR_I_BIT = 7;
   localparam int CCR_UI_BIT = 6;
   localparam int EXR_T_BIT = 7;
   // Register byte addresses (block-local map)
   localparam logic [7:0] ADDR_VBR = 8'h00;
   localparam logic [7:0] ADDR_CCR = 8'h04;
   localparam logic [7:0] ADDR_EXR = 8'h08;
   localparam logic [7:0] ADDR_HALT_A = 8'h0c;
   localparam logic [7:0] ADDR_HALT_B = 8'h10;
   localparam logic [7:0] ADDR_MODE = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [3:0] {
      ST_RESET = 4'h1,
      ST_RUN = 4'h2,
      ST_FETCH = 4'h4,
      ST_DONE = 4'h8
   } rtvu_state_t;
endpackage

// ===== verif/rtvu_top_properties.sv
module rtvu_checker (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic chip_init_pin_n_in,
   input wire logic wdt_overflow_in,
   input wire logic instr_done_in,
   input wire logic instr_is_rte_in,
   input wire logic fetch_req_out,
   input wire logic [31:0] fetch_addr_out,
   input wire logic fetch_ack_in,
   input wire logic exc_start_out,
   input wire logic [7:0] exc_vec_out,
   input wire logic pc_load_out,
   input wire logic cpu_in_reset_out,
   input wire logic [15:0] module_halt_a_out,
   input wire logic [15:0] module_halt_b_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic seen_done;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!resetn_in || !chip_init_pin_n_in);
   // Blocking window ends at first completed instruction
   always_ff @(posedge core_clk_in or negedge resetn_in or negedge chip_init_pin_n_in) begin
      if (!resetn_in || !chip_init_pin_n_in) begin
         seen_done <= 1'b0;
      end else if (cpu_in_reset_out) begin
         seen_done <= 1'b0;
      end else if (instr_done_in) begin
         seen_done <= 1'b1;
      end
   end
   pin_low_halt_a: assert property (disable iff (!resetn_in)
      !chip_init_pin_n_in |-> cpu_in_reset_out) else $error("pin low but core running");
   halt_reset_a: assert property (
      cpu_in_reset_out |-> module_halt_a_out == 16'h0fff && module_halt_b_out == 16'hffff)
      else $error("halt controls wrong in reset");
   reset_fetch_a: assert property (
      cpu_in_reset_out && !wdt_overflow_in |=> fetch_req_out && fetch_addr_out == 32'h0000_0000)
      else $error("reset vector fetch missing");
   pc_load_cause_a: assert property (
      pc_load_out |-> $past(fetch_req_out) && $past(fetch_ack_in)) else $error("stray pc load");
   addr_err_abs_a: assert property (
      exc_start_out && exc_vec_out == 8'h0c |-> fetch_req_out && fetch_addr_out == 32'h0000_0030)
      else $error("address error vector not absolute");
   no_reserved_vec_a: assert property (
      exc_start_out |-> !(exc_vec_out inside {[8'h13:8'h3f], [8'h4c:8'h4f]}))
      else $error("reserved vector generated");
   early_intr_block_a: assert property (
      instr_done_in && !seen_done && !cpu_in_reset_out |=> !(exc_start_out
      && (exc_vec_out == 8'h07 || exc_vec_out >= 8'h40))) else $error("interrupt before first op");
   rte_no_trace_a: assert property (
      instr_done_in && instr_is_rte_in |=> !(exc_start_out && exc_vec_out == 8'h05)
      ##1 !(exc_start_out && exc_vec_out == 8'h05)) else $error("trace after return");
   cover property (exc_start_out && exc_vec_out == 8'h05);
   cover property (exc_start_out && exc_vec_out == 8'h0c);
   cover property (pc_load_out && !seen_done);
endmodule

// ===== verif/rtvu_core_model.sv
module rtvu_core_model (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic req_in,
   input wire logic [31:0] addr_in,
   input wire logic [3:0] delay_in,
   output logic ack_out,
   output logic [31:0] data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_cnt;
   // Data toggles outside an answer so stale values never match
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wait_cnt <= 4'h0;
         ack_out <= 1'b0;
         data_out <= 32'h0000_0000;
      end else if (req_in && !ack_out && wait_cnt == delay_in) begin
         wait_cnt <= 4'h0;
         ack_out <= 1'b1;
         data_out <= addr_in ^ 32'h5a5a_0000;
      end else begin
         wait_cnt <= (req_in && !ack_out) ? wait_cnt + 4'h1 : 4'h0;
         ack_out <= 1'b0;
         data_out <= ~data_out;
      end
   end
endmodule

// ===== verif/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rstn = 1'b0, pin_n = 1'b0, wdt = 1'b0, done = 1'b0, return_from_exception_instr = 1'b0;
   logic ill = 1'b0, cae = 1'b0, xae = 1'b0, nmi = 1'b0, slp = 1'b0, iint = 1'b0, trp = 1'b0;
   logic [11:0] irq = 12'h000;
   logic [7:0] ivec = 8'h50, awaddr = 8'h00, araddr = 8'h00;
   logic [1:0] tnum = 2'h0;
   logic [2:0] prio = 3'h0;
   logic [3:0] dly = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic freq, ack, exs, pcl, inrst, awry, wry, bv, arry, rv;
   logic [31:0] faddr, fdata, pc, rdata, l_addr, l_pc, rd_d;
   logic [7:0] evec, sexr, sccr, l_vec, l_sexr;
   logic [15:0] ha, hb;
   logic [1:0] bresp, rresp, l_resp;
   int err_total = 0, n_compared = 0, n_pc = 0;
   logic [31:0] rst_v [7] = '{32'h0000_0000, 32'h0000_0080, 32'h0000_0007, 32'h0000_0fff,
      32'h0000_ffff, 32'h0000_0000, 32'h0000_0002};
   logic [7:0] vt [13] = '{8'h04, 8'h0c, 8'h0d, 8'h07, 8'h12, 8'h40, 8'h4b, 8'h50, 8'hff,
      8'h08, 8'h09, 8'h0a, 8'h0b};
   initial forever #25 clk = ~clk;
   rtvu_top i_rtvu_top (.core_clk_in(clk), .resetn_in(rstn), .chip_init_pin_n_in(pin_n),
      .wdt_overflow_in(wdt), .instr_done_in(done), .instr_is_rte_in(return_from_exception_instr), .illegal_instr_in(ill),
      .cpu_addr_err_in(cae), .xfer_addr_err_in(xae), .nmi_in(nmi), .sleep_intr_in(slp),
      .irq_in(irq), .internal_intr_in(iint), .internal_vec_in(ivec), .trap_in(trp),
      .trap_num_in(tnum), .irq_prio_in(prio), .fetch_req_out(freq), .fetch_addr_out(faddr),
      .fetch_ack_in(ack), .fetch_data_in(fdata), .exc_start_out(exs), .exc_vec_out(evec),
      .stacked_exr_out(sexr), .stacked_ccr_out(sccr), .pc_out(pc), .pc_load_out(pcl),
      .cpu_in_reset_out(inrst), .module_halt_a_out(ha), .module_halt_b_out(hb),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awry), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wry), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arry), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rry));
   rtvu_core_model i_rtvu_core_model (.clk_in(clk), .rstn_in(rstn && pin_n), .req_in(freq),
      .addr_in(faddr), .delay_in(dly), .ack_out(ack), .data_out(fdata));
   always @(posedge clk) begin
      if (exs === 1'b1) begin
         l_vec = evec;
         l_addr = faddr;
         l_sexr = sexr;
      end
      if (pcl === 1'b1) begin
         n_pc++;
         l_pc = pc;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awry) awv <= 1'b0;
         if (wry) wv <= 1'b0;
      end while (bv !== 1'b1);
      l_resp = bresp;
      bry <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do @(posedge clk); while (arry !== 1'b1);
      arv <= 1'b0;
      while (rv !== 1'b1) @(posedge clk);
      d = rdata;
      l_resp = rresp;
      rry <= 1'b0;
   endtask
   task automatic exc(input logic [7:0] v, input logic [31:0] base, input logic want,
      input logic r);
      int n0;
      n0 = n_pc;
      @(posedge clk);
      done <= 1'b1;
      return_from_exception_instr <= r;
      @(posedge clk);
      done <= 1'b0;
      return_from_exception_instr <= 1'b0;
      if (want) begin
         while (n_pc == n0) @(posedge clk);
         chk(l_vec, v);
         chk(l_addr, base + {v, 2'b00});
         chk(l_pc, (base + {v, 2'b00}) ^ 32'h5a5a_0000);
      end else begin
         repeat (8) @(posedge clk);
         chk(n_pc - n0, 0);
      end
   endtask
   task automatic set_src(input int k, input logic on);
      ill <= on && k == 0;
      cae <= on && k == 1;
      xae <= on && k == 2;
      nmi <= on && k == 3;
      slp <= on && k == 4;
      irq <= {on && k == 6, 10'h000, on && k == 5};
      iint <= on && (k == 7 || k == 8);
      ivec <= (k == 8) ? 8'hff : 8'h50;
      trp <= on && k > 8;
      tnum <= 2'(k - 9);
      dly <= k[3:0];
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #500000;
      err_total++;
      conclude();
   end
   initial begin
      int n0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      // Pin held low at least 20 cycles
      repeat (20) @(posedge clk);
      pin_n <= 1'b1;
      while (n_pc == 0) @(posedge clk);
      chk(l_pc, 32'h5a5a_0000);
      chk(ha, 32'h0000_0fff);
      chk(hb, 32'h0000_ffff);
      for (int i = 0; i < 7; i++) begin
         rd(8'(i * 4), rd_d);
         chk(rd_d, rst_v[i]);
      end
      $display("reset test done");
      nmi <= 1'b1;
      exc(8'h07, 32'h0000_0000, 1'b0, 1'b0);
      exc(8'h07, 32'h0000_0000, 1'b1, 1'b0);
      nmi <= 1'b0;
      wr(8'h00, 32'h0001_0000);
      for (int k = 0; k < 13; k++) begin
         wr(8'h04, 32'h0000_0000);
         set_src(k, 1'b1);
         exc(vt[k], (k == 1) ? 32'h0000_0000 : 32'h0001_0000, 1'b1, 1'b0);
         set_src(k, 1'b0);
      end
      $display("vector test done");
      wr(8'h08, 32'h0000_0080);
      exc(8'h05, 32'h0001_0000, 1'b0, 1'b0);
      // Trace bit cleared before mode change
      wr(8'h08, 32'h0000_0000);
      wr(8'h14, 32'h0000_0002);
      wr(8'h04, 32'h0000_0000);
      wr(8'h08, 32'h0000_0083);
      exc(8'h05, 32'h0001_0000, 1'b1, 1'b0);
      chk(l_sexr, 32'h0000_0083);
      chk(sccr, 32'h0000_0000);
      rd(8'h08, rd_d);
      chk(rd_d, 32'h0000_0003);
      rd(8'h04, rd_d);
      chk(rd_d, 32'h0000_0080);
      nmi <= 1'b1;
      exc(8'h07, 32'h0001_0000, 1'b1, 1'b0);
      nmi <= 1'b0;
      wr(8'h08, 32'h0000_0083);
      exc(8'h05, 32'h0001_0000, 1'b1, 1'b0);
      wr(8'h08, 32'h0000_0083);
      exc(8'h05, 32'h0001_0000, 1'b0, 1'b1);
      wr(8'h04, 32'h0000_0000);
      wr(8'h08, 32'h0000_0003);
      irq <= 12'h001;
      prio <= 3'h5;
      exc(8'h40, 32'h0001_0000, 1'b1, 1'b0);
      irq <= 12'h000;
      rd(8'h08, rd_d);
      chk(rd_d, 32'h0000_0005);
      $display("trace test done");
      rd(8'h40, rd_d);
      chk(l_resp, rtvu_pkg::RESP_SLVERR);
      chk(rd_d, 32'h0000_0000);
      wr(8'h40, 32'h0000_1234);
      chk(l_resp, rtvu_pkg::RESP_SLVERR);
      $display("unmapped test done");
      n0 = n_pc;
      wdt <= 1'b1;
      @(posedge clk);
      wdt <= 1'b0;
      while (n_pc == n0) @(posedge clk);
      chk(l_pc, 32'h5a5a_0000);
      rd(8'h14, rd_d);
      chk(rd_d, 32'h0000_0000);
      rd(8'h00, rd_d);
      chk(rd_d, 32'h0000_0000);
      $display("watchdog test done");
      conclude();
   end
endmodule
bind rtvu_top rtvu_checker i_rtvu_checker (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
   .chip_init_pin_n_in(chip_init_pin_n_in), .wdt_overflow_in(wdt_overflow_in),
   .instr_done_in(instr_done_in), .instr_is_rte_in(instr_is_rte_in),
   .fetch_req_out(fetch_req_out), .fetch_addr_out(fetch_addr_out), .fetch_ack_in(fetch_ack_in),
   .exc_start_out(exc_start_out), .exc_vec_out(exc_vec_out), .pc_load_out(pc_load_out),
   .cpu_in_reset_out(cpu_in_reset_out), .module_halt_a_out(module_halt_a_out),
   .module_halt_b_out(module_halt_b_out));
